// File: rtl/conv_status_params.svh
`ifndef CONV_STATUS_PARAMS_SVH
`define CONV_STATUS_PARAMS_SVH

// register byte addresses
`define ADDR_STATUS      32'hFFFF0500
`define ADDR_MASK        32'hFFFF0504
`define ADDR_MODE        32'hFFFF0508
`define ADDR_RES_CUR     32'hFFFF050C
`define ADDR_RES_VOLT    32'hFFFF0510
`define ADDR_RES_TEMP    32'hFFFF0514
`define ADDR_CONFIG      32'hFFFF0518
`define ADDR_CUR_CTRL    32'hFFFF051C
`define ADDR_THRESH      32'hFFFF0520
`define ADDR_CNT_LIMIT   32'hFFFF0524
`define ADDR_CNT_VALUE   32'hFFFF0528

// reset values
`define STATUS_RST       16'h0000
`define MASK_RST         8'h00
`define BYTE_RST         8'h00
`define HALF_RST         16'h0000
`define WORD_ZERO        32'h0000_0000

// status bit positions
`define BIT_CAL_DONE     15
`define BIT_ERR_BASE     12
`define BIT_CMP          4
`define BIT_GROSS_OVR    3
`define STATUS_USED      16'hF01F
`define IRQ_MSB          7

// configuration and control fields
`define CFG_GROSS_EN     2
`define CFG_CMP_EN       3
`define CFG_CH_EN_BASE   4
`define GAIN_MSB         3
`define GAIN_LSB         0

// clamp values
`define POS_FULL_SCALE   16'h7FFF
`define NEG_FULL_SCALE   16'h8000

// gross overrange sampling interval
`define CLK_PERIOD_NS    8
`define GROSS_PERIOD_NS  125000
`define TIMER_W          16

`endif

// File: rtl/conv_status_pkg.sv
package conv_status_pkg;

   localparam int NUM_CH = 3;

   // one conversion from a channel filter
   typedef struct packed {
      logic        valid;
      logic        over;
      logic        under;
      logic [15:0] data;
   } conv_result_s;

   typedef logic [15:0] half_t;

   typedef struct packed {
      half_t [NUM_CH-1:0] result;
      half_t              status;
      logic [7:0]         mask;
      logic [7:0]         mode;
      logic [7:0]         config_bits;
      half_t              cur_ctrl;
      half_t              thresh;
      logic [7:0]         cnt_limit;
      logic [7:0]         cnt_value;
      logic [15:0]        timer;
      logic [31:0]        prdata;
      logic               pready;
      logic               pslverr;
      logic               irq;
   } state_s;

endpackage

// File: rtl/conv_status_flags.sv
//  Behaviour
// - bit 15 set on calibration end, cleared by any mode register write.
// - bit 14 set on temperature range error, cleared on in-range stored result.
// - out-of-range results clamp to negative or positive full scale.
// - bit 13 set on voltage range error, cleared on in-range stored result.
// - bit 12 set on current range error, cleared on in-range stored result.
// - bits 11 to 5 reserved, read as zero, carry no function.
// - bit 4 valid with comparator on; set when current magnitude exceeds threshold.
// - with threshold counter used, bit 4 sets when exceed count reaches limit.
// - bit 4 cleared on reconfiguration or comparator disable.
// - bit 3 set when gross overrange detected, sampled every 125 us.
// - bit 3 cleared only by disabling detection or changing current gain.
// - bit 2 set when temperature result stored (channel on), also at calibration.
// - bit 2 cleared by reading temperature or current result.
// - bit 1 set when voltage result stored (channel on), also at calibration.
// - bit 1 cleared by reading voltage or current result.
// - bit 0 set when current result stored (channel on), also at calibration.
// - bit 0 cleared by reading current result, or voltage or temperature result with current channel off.
// - status register read-only, resets to zero.
// - bits 0 to 7 ORed into one interrupt; upper bits never interrupt.
// - each interrupting bit passes only when its mask bit is one.
// - a result register is not overwritten until ready clears, unless core down.
// - with current channel off, voltage or temperature read clears all ready flags.
`timescale 1ns/1ns
`include "conv_status_params.svh"

module conv_status_flags #(
   parameter int GROSS_TICKS = `GROSS_PERIOD_NS / `CLK_PERIOD_NS
) (
   // clock and reset
   input  wire logic                         pclk,
   input  wire logic                         presetn,
   // apb slave
   input  wire logic                         psel,
   input  wire logic                         penable,
   input  wire logic                         pwrite,
   input  wire logic [31:0]                  paddr,
   input  wire logic [31:0]                  pwdata,
   output logic      [31:0]                  prdata,
   output logic                              pready,
   output logic                              pslverr,
   // converter events: index 0 current, 1 voltage, 2 temperature
   input  wire conv_status_pkg::conv_result_s conv_cur,
   input  wire conv_status_pkg::conv_result_s conv_volt,
   input  wire conv_status_pkg::conv_result_s conv_temp,
   input  wire logic                         cal_done,
   input  wire logic                         gross_over,
   input  wire logic                         core_powered_down,
   // configuration to the converters and interrupt
   output logic      [7:0]                   mode_out,
   output logic      [7:0]                   config_out,
   output logic      [15:0]                  cur_ctrl_out,
   output logic                              conv_irq
);
   import conv_status_pkg::*;

   localparam logic [`TIMER_W-1:0] TICK_LAST =
      `TIMER_W'(GROSS_TICKS - 1);

   state_s s;
   state_s next_s;

   conv_result_s [NUM_CH-1:0] conv_in;
   logic                      wr_done;
   logic                      rd_done;
   logic                      setup;
   logic                      cur_on;
   logic                      tick;
   logic                      exceed;
   logic [NUM_CH-1:0]         stored;
   logic [NUM_CH-1:0]         rd_res;
   logic [15:0]               clamped;
   logic [7:0]                cnt_next;

   assign conv_in = {conv_temp, conv_volt, conv_cur};

   function automatic logic hit(input logic [31:0] a, input logic [31:0] r);
      hit = (a == r);
   endfunction

   function automatic logic mapped(input logic [31:0] a);
      mapped = hit(a, `ADDR_STATUS)    | hit(a, `ADDR_MASK)      |
               hit(a, `ADDR_MODE)      | hit(a, `ADDR_RES_CUR)   |
               hit(a, `ADDR_RES_VOLT)  | hit(a, `ADDR_RES_TEMP)  |
               hit(a, `ADDR_CONFIG)    | hit(a, `ADDR_CUR_CTRL)  |
               hit(a, `ADDR_THRESH)    | hit(a, `ADDR_CNT_LIMIT) |
               hit(a, `ADDR_CNT_VALUE);
   endfunction

   function automatic logic [15:0] magnitude(input logic [15:0] d);
      magnitude = d[15] ? 16'(~d + 16'h0001) : d;
   endfunction

   function automatic logic [31:0] read_mux(input state_s st,
                                            input logic [31:0] a);
      read_mux = `WORD_ZERO;
      case (a)
         `ADDR_STATUS:    read_mux = {16'h0000,
                                      st.status & `STATUS_USED};
         `ADDR_MASK:      read_mux = {24'h000000, st.mask};
         `ADDR_MODE:      read_mux = {24'h000000, st.mode};
         `ADDR_RES_CUR:   read_mux = {16'h0000, st.result[0]};
         `ADDR_RES_VOLT:  read_mux = {16'h0000, st.result[1]};
         `ADDR_RES_TEMP:  read_mux = {16'h0000, st.result[2]};
         `ADDR_CONFIG:    read_mux = {24'h000000, st.config_bits};
         `ADDR_CUR_CTRL:  read_mux = {16'h0000, st.cur_ctrl};
         `ADDR_THRESH:    read_mux = {16'h0000, st.thresh};
         `ADDR_CNT_LIMIT: read_mux = {24'h000000, st.cnt_limit};
         `ADDR_CNT_VALUE: read_mux = {24'h000000, st.cnt_value};
         default:         read_mux = `WORD_ZERO;
      endcase
   endfunction

   always_comb begin
      next_s   = s;
      setup    = psel & ~penable;
      wr_done  = psel & penable & s.pready & pwrite;
      rd_done  = psel & penable & s.pready & ~pwrite;
      cur_on   = s.config_bits[`CFG_CH_EN_BASE];
      tick     = (s.timer == TICK_LAST);
      exceed   = 1'b0;
      stored   = '0;
      clamped  = `HALF_RST;
      cnt_next = s.cnt_value;
      rd_res[0] = rd_done & hit(paddr, `ADDR_RES_CUR);
      rd_res[1] = rd_done & hit(paddr, `ADDR_RES_VOLT);
      rd_res[2] = rd_done & hit(paddr, `ADDR_RES_TEMP);

      // apb: no wait state, response data captured in setup
      next_s.pready  = setup;
      next_s.pslverr = setup & ~mapped(paddr);
      next_s.prdata  = setup ? read_mux(s, paddr) : `WORD_ZERO;

      // software writes; the status register ignores them
      if (wr_done) begin
         case (paddr)
            `ADDR_MASK:      next_s.mask        = pwdata[7:0];
            `ADDR_MODE:      next_s.mode        = pwdata[7:0];
            `ADDR_CONFIG:    next_s.config_bits = pwdata[7:0];
            `ADDR_CUR_CTRL:  next_s.cur_ctrl    = pwdata[15:0];
            `ADDR_THRESH:    next_s.thresh      = pwdata[15:0];
            `ADDR_CNT_LIMIT: next_s.cnt_limit   = pwdata[7:0];
            default:         next_s.mask        = s.mask;
         endcase
      end

      // clears first, so that sets below win
      if (wr_done & hit(paddr, `ADDR_MODE)) begin
         next_s.status[`BIT_CAL_DONE] = 1'b0;
         next_s.status[`BIT_CMP]      = 1'b0;
         next_s.cnt_value             = `BYTE_RST;
      end
      if (!next_s.config_bits[`CFG_CMP_EN]) begin
         next_s.status[`BIT_CMP] = 1'b0;
      end
      if (!next_s.config_bits[`CFG_GROSS_EN]) begin
         next_s.status[`BIT_GROSS_OVR] = 1'b0;
      end
      if (wr_done & hit(paddr, `ADDR_CUR_CTRL) &&
          pwdata[`GAIN_MSB:`GAIN_LSB] !=
          s.cur_ctrl[`GAIN_MSB:`GAIN_LSB]) begin
         next_s.status[`BIT_GROSS_OVR] = 1'b0;
      end
      if (rd_res[0]) begin
         next_s.status[2:0] = 3'b000;
      end
      if (rd_res[1]) begin
         next_s.status[1] = 1'b0;
      end
      if (rd_res[2]) begin
         next_s.status[2] = 1'b0;
      end
      if ((rd_res[1] | rd_res[2]) & ~cur_on) begin
         next_s.status[2:0] = 3'b000;
      end

      // per channel result storage and flags
      for (int ch = 0; ch < NUM_CH; ch++) begin
         if (conv_in[ch].over) begin
            clamped = `POS_FULL_SCALE;
         end else if (conv_in[ch].under) begin
            clamped = `NEG_FULL_SCALE;
         end else begin
            clamped = conv_in[ch].data;
         end
         // hold a result until its ready flag clears, except core down
         stored[ch] = conv_in[ch].valid &
                      (~s.status[ch] | core_powered_down);
         if (stored[ch]) begin
            next_s.result[ch] = clamped;
            if (!(conv_in[ch].over | conv_in[ch].under)) begin
               next_s.status[`BIT_ERR_BASE + ch] = 1'b0;
            end
            if (s.config_bits[`CFG_CH_EN_BASE + ch]) begin
               next_s.status[ch] = 1'b1;
            end
         end
         if (conv_in[ch].valid & (conv_in[ch].over | conv_in[ch].under)) begin
            next_s.status[`BIT_ERR_BASE + ch] = 1'b1;
         end
      end

      // current comparator, optionally through the exceed counter
      if (conv_in[0].valid & s.config_bits[`CFG_CMP_EN]) begin
         exceed = magnitude(conv_in[0].data) > s.thresh;
         if (conv_in[0].over | conv_in[0].under) begin
            exceed = 1'b1;
         end
         if (s.cnt_limit == `BYTE_RST) begin
            if (exceed) begin
               next_s.status[`BIT_CMP] = 1'b1;
            end
         end else if (exceed) begin
            cnt_next = 8'(s.cnt_value + 8'h01);
            // counter holds at the limit rather than wrap
            if (cnt_next >= s.cnt_limit) begin
               next_s.status[`BIT_CMP] = 1'b1;
               cnt_next = s.cnt_limit;
            end
            next_s.cnt_value = cnt_next;
         end else begin
            next_s.cnt_value = `BYTE_RST;
         end
      end

      // gross overrange sampled on a fixed interval, sticky between
      next_s.timer = tick ? '0 : `TIMER_W'(s.timer + 1'b1);
      if (tick & s.config_bits[`CFG_GROSS_EN] & gross_over) begin
         next_s.status[`BIT_GROSS_OVR] = 1'b1;
      end

      // calibration end marks every ready flag and the calibration bit
      if (cal_done) begin
         next_s.status[`BIT_CAL_DONE] = 1'b1;
         next_s.status[2:0]           = 3'b111;
      end

      next_s.status = next_s.status & `STATUS_USED;
      // only the low byte interrupts; taken from next flags, so no lag
      next_s.irq = |(next_s.status[`IRQ_MSB:0] & next_s.mask);
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s.result      <= '0;
         s.status      <= `STATUS_RST;
         s.mask        <= `MASK_RST;
         s.mode        <= `BYTE_RST;
         s.config_bits <= `BYTE_RST;
         s.cur_ctrl    <= `HALF_RST;
         s.thresh      <= `HALF_RST;
         s.cnt_limit   <= `BYTE_RST;
         s.cnt_value   <= `BYTE_RST;
         s.timer       <= '0;
         s.prdata      <= `WORD_ZERO;
         s.pready      <= 1'b0;
         s.pslverr     <= 1'b0;
         s.irq         <= 1'b0;
      end else begin
         s <= next_s;
      end
   end

   assign prdata       = s.prdata;
   assign pready       = s.pready;
   assign pslverr      = s.pslverr;
   assign mode_out     = s.mode;
   assign config_out   = s.config_bits;
   assign cur_ctrl_out = s.cur_ctrl;
   assign conv_irq     = s.irq;

endmodule // conv_status_flags

// File: dv/conv_status_flags_properties.sv
`timescale 1ns/1ns
`include "conv_status_params.svh"

module conv_status_flags_properties #(
   parameter int GROSS_TICKS = `GROSS_PERIOD_NS / `CLK_PERIOD_NS
) (
   // clock and reset
   input wire logic        pclk,
   input wire logic        presetn,
   // apb
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   // events and outputs
   input wire logic        cal_done,
   input wire logic        gross_over,
   input wire logic [7:0]  mode_out,
   input wire logic [7:0]  config_out,
   input wire logic [15:0] cur_ctrl_out,
   input wire logic        conv_irq
);
   logic [7:0] mask_q;
   int         gross_cnt;
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence setup_s; psel && !penable; endsequence
   sequence done_s; psel && penable && pready; endsequence
   // mask is not a port, so mirror it from the bus
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mask_q <= `MASK_RST;
         gross_cnt <= 0;
      end else begin
         if (psel && penable && pready && pwrite && paddr == `ADDR_MASK) begin
            mask_q <= pwdata[7:0];
         end
         gross_cnt <= (gross_over && config_out[`CFG_GROSS_EN]
                       && mask_q == 8'h08) ? gross_cnt + 1 : 0;
      end
   end
   ready_setup_a: assert property (setup_s |=> pready)
      else $error("no ready after setup");
   ready_access_a: assert property (pready |-> psel && penable)
      else $error("ready outside access");
   unmapped_err_a: assert property ((done_s ##0 (paddr > `ADDR_CNT_VALUE
      || paddr < `ADDR_STATUS)) |-> pslverr && prdata == 32'h0)
      else $error("unmapped access not refused");
   reserved_zero_a: assert property (
      (done_s ##0 (!pwrite && paddr == `ADDR_STATUS))
      |-> prdata[31:16] == 16'h0 && prdata[11:5] == 7'h00)
      else $error("reserved status bits not zero");
   cal_irq_a: assert property (
      cal_done && mask_q[2:0] != 3'h0 |=> conv_irq)
      else $error("no interrupt after calibration");
   irq_masked_a: assert property (
      mask_q == 8'h00 && $past(mask_q) == 8'h00 |-> !conv_irq)
      else $error("interrupt while fully masked");
   config_echo_a: assert property (
      (done_s ##0 (pwrite && paddr == `ADDR_CONFIG))
      |=> config_out == $past(pwdata[7:0]))
      else $error("config copy wrong");
   gross_irq_a: assert property (gross_cnt > GROSS_TICKS + 1 |-> conv_irq)
      else $error("overrange not flagged");
   mode_echo_a: assert property (
      (done_s ##0 (pwrite && paddr == `ADDR_MODE))
      |=> mode_out == $past(pwdata[7:0]))
      else $error("mode copy wrong");
   gain_echo_a: assert property (
      (done_s ##0 (pwrite && paddr == `ADDR_CUR_CTRL))
      |=> cur_ctrl_out == $past(pwdata[15:0]))
      else $error("current control copy wrong");
   // status and irq captured from one state, so they must agree
   irq_source_a: assert property (
      (done_s ##0 (!pwrite && paddr == `ADDR_STATUS))
      |-> $past(conv_irq) == |(prdata[7:0] & mask_q))
      else $error("interrupt does not follow low flags");
endmodule // conv_status_flags_properties

bind conv_status_flags conv_status_flags_properties #(
   .GROSS_TICKS(GROSS_TICKS)
) conv_status_flags_properties_i (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .cal_done(cal_done),
   .gross_over(gross_over), .config_out(config_out), .conv_irq(conv_irq),
   .mode_out(mode_out), .cur_ctrl_out(cur_ctrl_out)
);

// File: dv/conv_status_flags_tb_top.sv
`timescale 1ns/1ns
`include "conv_status_params.svh"

module conv_status_flags_tb_top;
   import conv_status_pkg::*;
   localparam int GT = 8;
   logic         pclk = 1'b0, presetn = 1'b0, core_pd = 1'b0;
   logic         psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic         cal_done = 1'b0, gross_over = 1'b0;
   logic [31:0]  paddr = 32'h0, pwdata = 32'h0, prdata;
   logic         pready, pslverr, conv_irq;
   logic [7:0]   mode_out, config_out;
   logic [15:0]  cur_ctrl_out, d, res [3];
   logic [32:0]  q [$];
   logic [32:0]  note;
   conv_result_s cv [3] = '{default: '0};
   int           failures = 0, n_compared = 0;

   conv_status_flags #(.GROSS_TICKS(GT)) conv_status_flags_i (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .conv_cur(cv[0]),
      .conv_volt(cv[1]), .conv_temp(cv[2]), .cal_done(cal_done),
      .gross_over(gross_over), .core_powered_down(core_pd),
      .mode_out(mode_out), .config_out(config_out),
      .cur_ctrl_out(cur_ctrl_out), .conv_irq(conv_irq));

   initial begin
      forever #4 pclk = ~pclk;
   end

   task automatic give_verdict;
      $display("compared %0d, failures %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask

   // reads queue their note at request time, checked when pready shows
   always @(posedge pclk) begin
      if (psel && penable && pready === 1'b1 && !pwrite) begin
         note = q.size() > 0 ? q.pop_front() : 33'h0DEADBEEF;
         n_compared++;
         if ({pslverr, prdata} !== note) begin
            failures++;
            $display("mismatch at %0t: got %h expected %h", $time,
                     {pslverr, prdata}, note);
         end
      end
   end

   task automatic apb(input logic w, input logic [31:0] a, dat,
                      input logic [32:0] e);
      int n = 0;
      @(posedge pclk);
      {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, dat};
      if (!w) q.push_back(e);
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1 && ++n < 16);
      if (n >= 16) failures++;
      {psel, penable} <= 2'b00;
   endtask
   task automatic rd(input logic [31:0] a, e);
      apb(1'b0, a, 32'h0, {1'b0, e});
   endtask
   task automatic st(input logic [15:0] e);
      rd(`ADDR_STATUS, {16'h0, e});
   endtask
   task automatic clr;
      rd(`ADDR_RES_CUR, {16'h0, res[0]});
   endtask
   task automatic conv(input int ch, input logic ov, un, input logic [15:0] v);
      @(posedge pclk);
      cv[ch] <= {1'b1, ov, un, v};
      @(posedge pclk);
      cv[ch].valid <= 1'b0;
   endtask
   // hold past two sampling ticks, then drop and wait two more
   task automatic gross_hold;
      gross_over <= 1'b1;
      repeat (2 * GT + 4) @(posedge pclk);
      gross_over <= 1'b0;
      repeat (2 * GT) @(posedge pclk);
   endtask

   initial begin
      void'($urandom(88));
      res = '{default: 16'h0};
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      st(16'h0000);
      apb(1'b1, `ADDR_STATUS, 32'hFFFF, 33'h0);
      st(16'h0000);
      rd(`ADDR_MASK, 32'h0);
      apb(1'b0, 32'hFFFF0600, 32'h0, {1'b1, 32'h0});
      $display("test reset and access done");
      apb(1'b1, `ADDR_MASK, 32'hFF, 33'h0);
      apb(1'b1, `ADDR_CONFIG, 32'h70, 33'h0);
      cal_done <= 1'b1;
      @(posedge pclk);
      cal_done <= 1'b0;
      st(16'h8007);
      apb(1'b1, `ADDR_MODE, 32'h01, 33'h0);
      st(16'h0007);
      rd(`ADDR_RES_VOLT, 32'h0);
      st(16'h0005);
      rd(`ADDR_RES_TEMP, 32'h0);
      st(16'h0001);
      clr;
      st(16'h0000);
      $display("test calibration and ready clear done");
      for (int ch = 0; ch < 3; ch++) begin
         d = 16'($urandom);
         conv(ch, 1'b0, 1'b0, d);
         conv(ch, 1'b0, 1'b0, ~d);
         st(16'h0001 << ch);
         rd(`ADDR_RES_CUR + 32'(4 * ch), {16'h0, d});
         res[ch] = d;
         clr;
         for (int k = 0; k < 2; k++) begin
            conv(ch, k == 0, k == 1, 16'($urandom));
            st((16'h0001 << ch) | (16'h1000 << ch));
            res[ch] = (k == 0) ? 16'h7FFF : 16'h8000;
            rd(`ADDR_RES_CUR + 32'(4 * ch), {16'h0, res[ch]});
            clr;
         end
         conv(ch, 1'b0, 1'b0, d);
         st(16'h0001 << ch);
         res[ch] = d;
         clr;
      end
      $display("test results, clamps and errors done");
      apb(1'b1, `ADDR_CONFIG, 32'h60, 33'h0);
      conv(0, 1'b1, 1'b0, 16'h0000);
      st(16'h1000);
      conv(0, 1'b0, 1'b0, 16'h0055);
      conv(1, 1'b0, 1'b0, 16'h1234);
      conv(2, 1'b0, 1'b0, 16'h0042);
      st(16'h0006);
      rd(`ADDR_RES_VOLT, 32'h1234);
      st(16'h0000);
      core_pd <= 1'b1;
      conv(1, 1'b0, 1'b0, 16'h0101);
      conv(1, 1'b0, 1'b0, 16'h0202);
      rd(`ADDR_RES_VOLT, 32'h0202);
      core_pd <= 1'b0;
      $display("test channel off and power down done");
      apb(1'b1, `ADDR_THRESH, 32'h0100, 33'h0);
      apb(1'b1, `ADDR_CONFIG, 32'h78, 33'h0);
      conv(0, 1'b0, 1'b0, 16'h0100);
      st(16'h0001);
      conv(0, 1'b0, 1'b0, 16'hFE00);
      st(16'h0011);
      apb(1'b1, `ADDR_CONFIG, 32'h70, 33'h0);
      st(16'h0001);
      res[0] = 16'h0100;
      clr;
      apb(1'b1, `ADDR_CNT_LIMIT, 32'h03, 33'h0);
      apb(1'b1, `ADDR_CONFIG, 32'h78, 33'h0);
      conv(0, 1'b0, 1'b0, 16'h0010);
      conv(0, 1'b0, 1'b0, 16'h0300);
      conv(0, 1'b0, 1'b0, 16'hFD00);
      st(16'h0001);
      conv(0, 1'b0, 1'b0, 16'h0300);
      st(16'h0011);
      apb(1'b1, `ADDR_CNT_VALUE, 32'h07, 33'h0);
      rd(`ADDR_CNT_VALUE, 32'h03);
      apb(1'b1, `ADDR_MODE, 32'h02, 33'h0);
      st(16'h0001);
      res[0] = 16'h0010;
      clr;
      apb(1'b1, `ADDR_MASK, 32'h08, 33'h0);
      apb(1'b1, `ADDR_CONFIG, 32'h74, 33'h0);
      gross_hold;
      st(16'h0008);
      apb(1'b1, `ADDR_CUR_CTRL, 32'h01, 33'h0);
      st(16'h0000);
      gross_hold;
      st(16'h0008);
      apb(1'b1, `ADDR_CONFIG, 32'h70, 33'h0);
      st(16'h0000);
      rd(`ADDR_CUR_CTRL, 32'h01);
      rd(`ADDR_CNT_VALUE, 32'h00);
      rd(`ADDR_THRESH, 32'h0100);
      rd(`ADDR_CNT_LIMIT, 32'h03);
      rd(`ADDR_CONFIG, 32'h70);
      rd(`ADDR_MODE, 32'h02);
      $display("test comparator and overrange done");
      give_verdict;
   end

   // about twelve times the expected run
   initial begin
      repeat (5000) @(posedge pclk);
      $display("timeout");
      failures++;
      give_verdict;
   end
endmodule // conv_status_flags_tb_top
